// file: core/pin_ctl_pkg.sv
`default_nettype none
package pin_ctl_pkg;
  // ------------------------------------------------------------
  // register map (word offsets on the plain register port)
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFF_PIN_CTRL = 4'h0;
  localparam logic [3:0] OFF_UNLOCK = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;

  // ------------------------------------------------------------
  // pin control field positions
  // ------------------------------------------------------------
  localparam int HIGH_OWNER_BIT = 15;
  localparam int LOW_OWNER_BIT = 14;
  localparam int HIGH_POL_BIT = 13;
  localparam int LOW_POL_BIT = 12;
  localparam int MODE_MSB = 11;
  localparam int MODE_LSB = 10;
  localparam int HIGH_OVR_EN_BIT = 9;
  localparam int LOW_OVR_EN_BIT = 8;
  localparam int OVR_MSB = 7;
  localparam int OVR_LSB = 6;
  localparam int FAULT_MSB = 5;
  localparam int FAULT_LSB = 4;
  localparam int LIMIT_MSB = 3;
  localparam int LIMIT_LSB = 2;
  localparam int SWAP_BIT = 1;
  localparam int SYNC_BIT = 0;
  localparam logic [15:0] PIN_CTRL_RESET = 16'hc000;

  // pair modes
  localparam logic [1:0] MODE_COMPL = 2'h0;
  localparam logic [1:0] MODE_INDEP = 2'h1;
  localparam logic [1:0] MODE_PUSH_PULL = 2'h2;

  // unlock keys, values arbitrary
  localparam logic [15:0] UNLOCK_KEY1 = 16'h5a5a;
  localparam logic [15:0] UNLOCK_KEY2 = 16'ha5a5;
endpackage
`default_nettype wire

// file: core/unlock_if.sv
`default_nettype none
interface unlock_if;
  logic key_wr;
  logic [15:0] key_data;
  logic ctrl_wr;
  logic open;
  modport ctl (output key_wr, output key_data, output ctrl_wr, input open);
  modport seq (input key_wr, input key_data, input ctrl_wr, output open);
endinterface
`default_nettype wire

// file: core/unlock_seq.sv
`default_nettype none
module unlock_seq (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  unlock_if.seq bus
);
  typedef enum logic [2:0] {
    ST_LOCKED = 3'h1,
    ST_KEY1 = 3'h2,
    ST_OPEN = 3'h4
  } lock_state_t;

  lock_state_t state_reg;
  lock_state_t state_next;

  // two key writes in a row open one control write; any other key breaks it
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_LOCKED: begin
        if (bus.key_wr && bus.key_data == pin_ctl_pkg::UNLOCK_KEY1) state_next = ST_KEY1;
      end
      ST_KEY1: begin
        if (bus.key_wr) state_next = (bus.key_data == pin_ctl_pkg::UNLOCK_KEY2) ? ST_OPEN : ST_LOCKED;
      end
      ST_OPEN: begin
        if (bus.ctrl_wr || bus.key_wr) state_next = ST_LOCKED;
      end
      default: state_next = ST_LOCKED;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_LOCKED;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign bus.open = (state_reg == ST_OPEN);
endmodule // unlock_seq
`default_nettype wire

// file: core/pwm_output_pin_control.sv
// Contract
// - ownership bit per pin, reset one
// - polarity bit one makes pin active-low
// - mode 10 push-pull, 00 complementary, 11 reserved
// - high override shows override value bit 1
// - active enabled limit forces limit values
// - lock fuse needs unlock before each write
// - reset clears fields, owner bits set
//
// The strobed register port and the address map were decided locally.
`default_nettype none
module pwm_output_pin_control (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic write_lock_fuse,
  input wire logic module_enable_bit,
  input wire logic period_start,
  input wire logic gen_high,
  input wire logic gen_low,
  input wire logic fault_active,
  input wire logic fault_enable,
  input wire logic limit_active,
  input wire logic limit_enable,
  input wire logic gpio_high,
  input wire logic gpio_low,
  output logic high_side_output,
  output logic low_side_output
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [1:0] ovr_live_reg;
  logic [1:0] ovr_live_next;
  logic pp_phase_reg;
  logic pp_phase_next;
  logic high_reg;
  logic high_next;
  logic low_reg;
  logic low_next;
  logic mode_locked_wr;
  logic ctrl_sel;

  unlock_if ul ();

  unlock_seq u_unlock (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .bus(ul.seq)
  );

  // polarity as an xor: one on the bit inverts the active level
  function automatic logic to_pin(input logic active, input logic pol);
    return active ^ pol;
  endfunction

  assign ctrl_sel = reg_wr && reg_addr == pin_ctl_pkg::OFF_PIN_CTRL;
  assign ul.key_wr = reg_wr && reg_addr == pin_ctl_pkg::OFF_UNLOCK;
  assign ul.key_data = reg_wdata;
  assign ul.ctrl_wr = ctrl_sel;
  // the mode may not move once the generator runs; such writes keep the old mode
  assign mode_locked_wr = module_enable_bit;

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_sel && (!write_lock_fuse || ul.open)) begin
      ctrl_next = reg_wdata;
      if (mode_locked_wr) begin
        ctrl_next[pin_ctl_pkg::MODE_MSB:pin_ctl_pkg::MODE_LSB] =
          ctrl_reg[pin_ctl_pkg::MODE_MSB:pin_ctl_pkg::MODE_LSB];
      end
    end
    rdata_next = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        pin_ctl_pkg::OFF_PIN_CTRL: rdata_next = ctrl_reg;
        pin_ctl_pkg::OFF_STATUS: rdata_next = {10'h000, ul.open, write_lock_fuse,
                                               fault_active, limit_active, high_reg, low_reg};
        default: rdata_next = 16'h0000; // unmapped and unlock key read zero
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= pin_ctl_pkg::PIN_CTRL_RESET;
      rdata_reg <= 16'h0000;
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ------------------------------------------------------------
  // pin output stage
  // ------------------------------------------------------------
  // override enables take effect immediately, or at the next period start when synchronised
  always_comb begin
    logic g_hi;
    logic g_lo;
    logic act_hi;
    logic act_lo;
    logic [1:0] mode;
    g_hi = 1'b0;
    g_lo = 1'b0;
    act_hi = 1'b0;
    act_lo = 1'b0;
    mode = ctrl_reg[pin_ctl_pkg::MODE_MSB:pin_ctl_pkg::MODE_LSB];
    ovr_live_next = ovr_live_reg;
    if (!ctrl_reg[pin_ctl_pkg::SYNC_BIT] || period_start) begin
      ovr_live_next = ctrl_reg[pin_ctl_pkg::HIGH_OVR_EN_BIT:pin_ctl_pkg::LOW_OVR_EN_BIT];
    end
    pp_phase_next = period_start ? !pp_phase_reg : pp_phase_reg;
    // swap exchanges gen_high and gen_low; only independent mode then routes the generator's high to the low pin
    g_hi = ctrl_reg[pin_ctl_pkg::SWAP_BIT] ? gen_low : gen_high;
    g_lo = ctrl_reg[pin_ctl_pkg::SWAP_BIT] ? gen_high : gen_low;
    unique case (mode)
      pin_ctl_pkg::MODE_PUSH_PULL: begin
        act_hi = g_hi && !pp_phase_reg;
        act_lo = g_hi && pp_phase_reg;
      end
      pin_ctl_pkg::MODE_INDEP: begin
        act_hi = g_hi;
        act_lo = g_lo;
      end
      default: begin
        // reserved code falls back to complementary so the pair is never both on
        act_hi = g_hi;
        act_lo = !g_hi;
      end
    endcase
    high_next = to_pin(act_hi, ctrl_reg[pin_ctl_pkg::HIGH_POL_BIT]);
    low_next = to_pin(act_lo, ctrl_reg[pin_ctl_pkg::LOW_POL_BIT]);
    if (ovr_live_reg[1]) high_next = ctrl_reg[pin_ctl_pkg::OVR_MSB];
    if (ovr_live_reg[0]) low_next = ctrl_reg[pin_ctl_pkg::OVR_LSB];
    if (limit_active && limit_enable) begin
      high_next = ctrl_reg[pin_ctl_pkg::LIMIT_MSB];
      low_next = ctrl_reg[pin_ctl_pkg::LIMIT_LSB];
    end
    // fault beats limit: it is the harder protection case
    if (fault_active && fault_enable) begin
      high_next = ctrl_reg[pin_ctl_pkg::FAULT_MSB];
      low_next = ctrl_reg[pin_ctl_pkg::FAULT_LSB];
    end
    if (!ctrl_reg[pin_ctl_pkg::HIGH_OWNER_BIT]) high_next = gpio_high;
    if (!ctrl_reg[pin_ctl_pkg::LOW_OWNER_BIT]) low_next = gpio_low;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ovr_live_reg <= 2'h0;
      pp_phase_reg <= 1'b0;
      high_reg <= 1'b0;
      low_reg <= 1'b0;
    end else if (clk_en) begin
      ovr_live_reg <= ovr_live_next;
      pp_phase_reg <= pp_phase_next;
      high_reg <= high_next;
      low_reg <= low_next;
    end
  end

  assign high_side_output = high_reg;
  assign low_side_output = low_reg;
endmodule // pwm_output_pin_control
`default_nettype wire

// file: dv/power_stage.sv
`default_nettype none
// ----
// power stage load
// ----
module power_stage (
  input wire logic core_clk,
  input wire logic high_in,
  input wire logic low_in,
  output logic shoot_thru
);
  timeunit 1ns;
  timeprecision 1ps;
  // both switches on at once shorts the rail, so flag it
  always_ff @(posedge core_clk) shoot_thru <= high_in & low_in;
endmodule // power_stage
`default_nettype wire

// file: dv/pin_ctl_props.sv
`default_nettype none
module pin_ctl_props (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic gen_high,
  input wire logic fault_active,
  input wire logic fault_enable,
  input wire logic limit_active,
  input wire logic limit_enable,
  input wire logic gpio_high,
  input wire logic gpio_low,
  input wire logic high_side_output,
  input wire logic low_side_output
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // control shadow
  // ----
  logic [15:0] s;
  logic known, pend;
  wire logic flt = fault_active & fault_enable;
  wire logic lim = limit_active & limit_enable;
  wire logic ok = known & clk_en;
  wire logic free = !flt & !lim;
  // shadow comes from read-back only, so the lock need not be modelled
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend <= 1'b0;
      known <= 1'b0;
      s <= 16'h0;
    end else if (clk_en) begin
      pend <= reg_rd && reg_addr == 4'h0;
      known <= (pend | known) & !reg_wr;
      if (pend) s <= reg_rdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  gpio_high_a: assert property (ok && !s[15] |=> high_side_output == $past(gpio_high))
    else $error("high pin not from gpio");
  gpio_low_a: assert property (ok && !s[14] |=> low_side_output == $past(gpio_low))
    else $error("low pin not from gpio");
  fault_force_a: assert property (ok && &s[15:14] && flt |=> {high_side_output, low_side_output} == s[5:4])
    else $error("fault level wrong");
  limit_force_a: assert property (ok && &s[15:14] && !flt && lim |=> {high_side_output, low_side_output} == s[3:2])
    else $error("limit level wrong");
  high_ovr_a: assert property (ok && s[15] && free && s[9] && !s[0] |=> high_side_output == s[7])
    else $error("high override wrong");
  low_ovr_a: assert property (ok && s[14] && free && s[8] && !s[0] |=> low_side_output == s[6])
    else $error("low override wrong");
  gen_pol_a: assert property (ok && s[15] && free && s[11:9] == 3'h2 && !s[1] |=> high_side_output == ($past(gen_high) ^ s[13]))
    else $error("high pin polarity wrong");
  compl_low_a: assert property (ok && s[14] && free && s[11:10] == 2'h0 && !s[8] && !s[1] |=> low_side_output == (!$past(gen_high) ^ s[12]))
    else $error("complement wrong");
  cover property (ok && flt);
  cover property (ok && lim && !flt);
  cover property (reg_rd && reg_addr == 4'h8);
endmodule // pin_ctl_props
bind pwm_output_pin_control pin_ctl_props u_props (
  .core_clk(core_clk),
  .rstn(rstn),
  .clk_en(clk_en),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .gen_high(gen_high),
  .fault_active(fault_active),
  .fault_enable(fault_enable),
  .limit_active(limit_active),
  .limit_enable(limit_enable),
  .gpio_high(gpio_high),
  .gpio_low(gpio_low),
  .high_side_output(high_side_output),
  .low_side_output(low_side_output)
);
`default_nettype wire

// file: dv/pwm_output_pin_control_bench.sv
`default_nettype none
module pwm_output_pin_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rstn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic write_lock_fuse = 0, module_enable_bit = 0, period_start = 0, gen_high = 0, gen_low = 0;
  logic fault_active = 0, fault_enable = 0, limit_active = 0, limit_enable = 0, gpio_high = 0, gpio_low = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata;
  logic high_side_output, low_side_output, shoot_thru;
  int failures = 0, samples_checked = 0;
  pwm_output_pin_control u_dut (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .write_lock_fuse(write_lock_fuse),
    .module_enable_bit(module_enable_bit),
    .period_start(period_start),
    .gen_high(gen_high),
    .gen_low(gen_low),
    .fault_active(fault_active),
    .fault_enable(fault_enable),
    .limit_active(limit_active),
    .limit_enable(limit_enable),
    .gpio_high(gpio_high),
    .gpio_low(gpio_low),
    .high_side_output(high_side_output),
    .low_side_output(low_side_output)
  );
  power_stage u_stage (.core_clk(core_clk), .high_in(high_side_output), .low_in(low_side_output), .shoot_thru(shoot_thru));
  always #5 core_clk = ~core_clk;
  // ----
  // bus and compare helpers
  // ----
  task automatic chk(logic [15:0] g, logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // pins are registered, so two edges is ample settling
  task automatic pins(logic [1:0] e);
    repeat (2) @(posedge core_clk);
    #1 chk({14'h0, high_side_output, low_side_output}, {14'h0, e});
  endtask
  task automatic print_verdict();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_lock();
    rd(4'h0, 16'hc000);
    rd(4'hc, 16'h0);
    @(posedge core_clk);
    write_lock_fuse <= 1'b1;
    wr(4'h0, 16'hc100);
    rd(4'h0, 16'hc000);
    wr(4'h4, pin_ctl_pkg::UNLOCK_KEY1);
    wr(4'h4, pin_ctl_pkg::UNLOCK_KEY2);
    rd(4'h8, 16'h0031);
    wr(4'h0, 16'hc100);
    wr(4'h0, 16'hc000);
    rd(4'h0, 16'hc100);
    write_lock_fuse <= 1'b0;
    $display("lock test done");
  endtask
  task automatic t_force();
    wr(4'h0, 16'hc3e4);
    rd(4'h0, 16'hc3e4);
    fault_active <= 1'b1;
    fault_enable <= 1'b1;
    limit_active <= 1'b1;
    limit_enable <= 1'b1;
    pins(2'b10);
    fault_enable <= 1'b0;
    pins(2'b01);
    limit_active <= 1'b0;
    pins(2'b11);
    $display("force test done");
  endtask
  task automatic t_gen();
    wr(4'h0, 16'he400);
    rd(4'h0, 16'he400);
    gen_high <= 1'b1;
    pins(2'b00);
    wr(4'h0, 16'hc000);
    pins(2'b10);
    chk({15'h0, shoot_thru}, 16'h0);
    gen_low <= 1'b1;
    wr(4'h0, 16'hc800);
    pins(2'b10);
    period_start <= 1'b1;
    @(posedge core_clk);
    period_start <= 1'b0;
    pins(2'b01);
    module_enable_bit <= 1'b1;
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'h0800);
    gpio_high <= 1'b1;
    pins(2'b10);
    // a low clock enable must hold the pins even when their source moves
    clk_en <= 1'b0;
    gpio_high <= 1'b0;
    pins(2'b10);
    clk_en <= 1'b1;
    pins(2'b00);
    $display("generator test done");
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    t_lock();
    t_force();
    t_gen();
    print_verdict();
  end
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #50us;
    failures++;
    print_verdict();
  end
endmodule // pwm_output_pin_control_bench
`default_nettype wire
